/* hw/disk_ctrl_resource_decoder.sv */
// floppy and hard disk controller resource decoder with config registers
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: floppy answers at 3F2h, 3F4h and 3F5h in its legacy set.
// R2: floppy never reports 3F7h among its claimed resources.
// R3: floppy interrupt can drive interrupt line 6.
// R4: floppy dma request can use channel 2.
// R5: floppy can be disabled entirely.
// R6: floppy and hard disk disable separately; the other keeps working.
// R7: floppy relocatable to 372h, 374h, 375h and further sets.
// R8: floppy never reports 377h among its claimed resources.
// R9: floppy offers six more address sets plus decode off.
// R10: write protect reads asserted while no medium is present.
// R11: floppy interrupt routes to six more lines or disconnects.
// R12: hard disk decodes 1F0h to 1F7h plus 3F6h.
// R13: hard disk interrupt can drive interrupt line 14.
// R14: hard disk dma selects among three channels.
// R15: hard disk never reports 3F7h among its claimed resources.
// R16: hard disk can be disabled.
// R17: floppy dma selects two channels beyond channel 2.
// R18: disabled controller decodes nothing and keeps requests inactive.
// R19: software writes selections; routing follows the held selections.
module disk_ctrl_resource_decoder #(
   parameter int IRQ_LINES = 16,
   parameter int DMA_CHANS = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [disk_ctrl_pkg::REG_AW-1:0] reg_addr,
   input wire logic [disk_ctrl_pkg::REG_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [disk_ctrl_pkg::REG_DW-1:0] reg_rdata,
   output logic dev_int,
   input wire logic [disk_ctrl_pkg::IO_AW-1:0] io_addr,
   input wire logic io_strobe,
   output logic fdc_cs,
   output logic fdc_shared_cs,
   output logic hdc_cmd_cs,
   output logic hdc_ctl_cs,
   output logic [2:0] io_ofs,
   input wire logic fdc_irq_req,
   input wire logic hdc_irq_req,
   input wire logic fdc_drq_req,
   input wire logic hdc_drq_req,
   output logic fdc_dack,
   output logic hdc_dack,
   output logic [IRQ_LINES-1:0] irq_line,
   output logic [DMA_CHANS-1:0] drq_line,
   input wire logic [DMA_CHANS-1:0] dack_line,
   input wire logic media_present,
   input wire logic drive_wp,
   output logic host_wp
);
   import disk_ctrl_pkg::*;
   // ==========================================================
   // parameter checks
   if (IRQ_LINES < IRQ_LINES_MIN) begin : g_chk_irq
      $error("IRQ_LINES too small for the routing tables");
   end
   if (DMA_CHANS < DMA_CHANS_MIN) begin : g_chk_dma
      $error("DMA_CHANS too small for the routing tables");
   end
   // ==========================================================
   // reset release
   logic rst_meta_n, rst_sync_n;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end
   // ==========================================================
   // configuration registers
   logic fdc_en, hdc_en, wr_status;
   logic [3:0] fdc_io;
   logic [2:0] fdc_irq_sel, hdc_io, hdc_irq_sel;
   logic [1:0] fdc_dma_sel, hdc_dma_sel;
   logic [INT_W-1:0] int_status, int_mask, int_event;
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         fdc_en <= CTRL_RESET[CTRL_FDC_EN];
         hdc_en <= CTRL_RESET[CTRL_HDC_EN];
      end else if (reg_wr && reg_addr == OFF_CTRL) begin
         fdc_en <= reg_wdata[CTRL_FDC_EN]; // R5 R6
         hdc_en <= reg_wdata[CTRL_HDC_EN]; // R16 R6
      end
   end
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         fdc_io <= FDC_IO_RESET;
         fdc_irq_sel <= '0;
         fdc_dma_sel <= '0;
         hdc_io <= HDC_IO_RESET;
         hdc_irq_sel <= '0;
         hdc_dma_sel <= '0;
      end else if (reg_wr) begin // R19
         case (reg_addr)
            OFF_FDC_IO: begin
               // codes above the off code fold onto decode off
               fdc_io <= (reg_wdata[3:0] > FDC_IO_OFF) ? FDC_IO_OFF
                                                       : reg_wdata[3:0];
            end
            OFF_FDC_IRQ: fdc_irq_sel <= reg_wdata[2:0];
            OFF_FDC_DMA: fdc_dma_sel <= reg_wdata[1:0];
            OFF_HDC_IO: hdc_io <= reg_wdata[2:0];
            OFF_HDC_IRQ: hdc_irq_sel <= reg_wdata[2:0];
            OFF_HDC_DMA: hdc_dma_sel <= reg_wdata[1:0];
            default: begin
            end
         endcase
      end
   end
   // ==========================================================
   // interrupt status, write one to clear, new event wins
   assign wr_status = reg_wr && (reg_addr == OFF_INT_STATUS);
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         int_status <= '0;
      end else begin
         int_status <= (int_status & ~(wr_status ? reg_wdata[INT_W-1:0]
                                                  : '0)) | int_event;
      end
   end
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         int_mask <= '0;
      end else if (reg_wr && reg_addr == OFF_INT_MASK) begin
         int_mask <= reg_wdata[INT_W-1:0];
      end
   end
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dev_int <= 1'b0;
      end else begin
         dev_int <= |(int_status & int_mask);
      end
   end
   // ==========================================================
   // event detection
   logic fdc_irq_prev, hdc_irq_prev, media_prev, edge_armed;
   // media idles at either level, so its first sample only arms the edge
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         fdc_irq_prev <= 1'b0;
         hdc_irq_prev <= 1'b0;
         media_prev <= 1'b0;
         edge_armed <= 1'b0;
      end else begin
         fdc_irq_prev <= fdc_irq_req;
         hdc_irq_prev <= hdc_irq_req;
         media_prev <= media_present;
         edge_armed <= 1'b1;
      end
   end
   // a disabled controller raises no event
   always_comb begin
      int_event = '0;
      int_event[INT_FDC] = fdc_en && fdc_irq_req && !fdc_irq_prev;
      int_event[INT_HDC] = hdc_en && hdc_irq_req && !hdc_irq_prev;
      int_event[INT_MEDIA] = edge_armed && (media_present ^ media_prev);
   end
   // ==========================================================
   // register read, data in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         case (reg_addr)
            OFF_CTRL: begin
               reg_rdata[CTRL_FDC_EN] <= fdc_en;
               reg_rdata[CTRL_HDC_EN] <= hdc_en;
            end
            OFF_FDC_IO: reg_rdata[3:0] <= fdc_io;
            OFF_FDC_IRQ: reg_rdata[2:0] <= fdc_irq_sel;
            OFF_FDC_DMA: reg_rdata[1:0] <= fdc_dma_sel;
            OFF_HDC_IO: reg_rdata[2:0] <= hdc_io;
            OFF_HDC_IRQ: reg_rdata[2:0] <= hdc_irq_sel;
            OFF_HDC_DMA: reg_rdata[1:0] <= hdc_dma_sel;
            OFF_FDC_RES: reg_rdata[7:0] <= FDC_CLAIM_MASK; // R2 R8
            OFF_HDC_RES: reg_rdata[7:0] <= HDC_CTL_CLAIM_MASK; // R15
            OFF_INT_STATUS: reg_rdata[INT_W-1:0] <= int_status;
            OFF_INT_MASK: reg_rdata[INT_W-1:0] <= int_mask;
            OFF_STATUS: begin
               reg_rdata[STAT_MEDIA] <= media_present;
               reg_rdata[STAT_WP] <= host_wp;
            end
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end
   // ==========================================================
   // i/o address decode
   logic fdc_live, hdc_live, fdc_blk, hdc_cmd_blk, hdc_ctl_blk;
   assign fdc_live = fdc_en && (fdc_io != FDC_IO_OFF); // R18
   assign hdc_live = hdc_en && (hdc_io != HDC_IO_OFF); // R18
   assign fdc_blk = fdc_live && (io_addr[IO_AW-1:3] == // R1 R7 R9
                                 FDC_BASE[fdc_io[2:0]][IO_AW-1:3]);
   assign hdc_cmd_blk = hdc_live && (io_addr[IO_AW-1:3] == // R12
                                     HDC_CMD_BASE[hdc_io][IO_AW-1:3]);
   assign hdc_ctl_blk = hdc_live && (io_addr[IO_AW-1:3] ==
                                     HDC_CTL_BASE[hdc_io][IO_AW-1:3]);
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         fdc_cs <= 1'b0;
         fdc_shared_cs <= 1'b0;
         hdc_cmd_cs <= 1'b0;
         hdc_ctl_cs <= 1'b0;
         io_ofs <= '0;
      end else begin
         fdc_cs <= io_strobe && fdc_blk && (io_addr[2:0] == FDC_OFS_A ||
                   io_addr[2:0] == FDC_OFS_B ||
                   io_addr[2:0] == FDC_OFS_C); // R1 R7
         // shared offset is passed on but never counted as claimed
         fdc_shared_cs <= io_strobe && fdc_blk &&
                          (io_addr[2:0] == SHARED_OFS); // R2 R8
         hdc_cmd_cs <= io_strobe && hdc_cmd_blk; // R12
         hdc_ctl_cs <= io_strobe && hdc_ctl_blk &&
                       (io_addr[2:0] == HDC_CTL_OFS); // R12 R15
         io_ofs <= io_addr[2:0];
      end
   end
   // ==========================================================
   // interrupt and dma routing
   logic [IRQ_LINES-1:0] fdc_irq_lines, hdc_irq_lines;
   logic [DMA_CHANS-1:0] fdc_drq_lines, hdc_drq_lines;
   logic fdc_ack, hdc_ack;
   // R3 R11
   request_router #(.LINES(IRQ_LINES), .SELW(3), .NONE_CODE(IRQ_NONE),
      .MAP(FDC_IRQ_MAP)) u_fdc_irq (
      .enable(fdc_en),
      .sel(fdc_irq_sel),
      .req(fdc_irq_req),
      .ack_in('0),
      .line_out(fdc_irq_lines),
      .ack_out()
   );
   // R13
   request_router #(.LINES(IRQ_LINES), .SELW(3), .NONE_CODE(IRQ_NONE),
      .MAP(HDC_IRQ_MAP)) u_hdc_irq (
      .enable(hdc_en),
      .sel(hdc_irq_sel),
      .req(hdc_irq_req),
      .ack_in('0),
      .line_out(hdc_irq_lines),
      .ack_out()
   );
   // R4 R17
   request_router #(.LINES(DMA_CHANS), .SELW(2), .NONE_CODE(DMA_NONE),
      .MAP(FDC_DMA_MAP)) u_fdc_dma (
      .enable(fdc_en),
      .sel(fdc_dma_sel),
      .req(fdc_drq_req),
      .ack_in(dack_line),
      .line_out(fdc_drq_lines),
      .ack_out(fdc_ack)
   );
   // R14
   request_router #(.LINES(DMA_CHANS), .SELW(2), .NONE_CODE(DMA_NONE),
      .MAP(HDC_DMA_MAP)) u_hdc_dma (
      .enable(hdc_en),
      .sel(hdc_dma_sel),
      .req(hdc_drq_req),
      .ack_in(dack_line),
      .line_out(hdc_drq_lines),
      .ack_out(hdc_ack)
   );
   // both may pick one line; or-ing keeps each working alone
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_line <= '0;
         drq_line <= '0;
         fdc_dack <= 1'b0;
         hdc_dack <= 1'b0;
      end else begin
         irq_line <= fdc_irq_lines | hdc_irq_lines; // R19 R6
         drq_line <= fdc_drq_lines | hdc_drq_lines; // R19 R18
         fdc_dack <= fdc_ack;
         hdc_dack <= hdc_ack;
      end
   end
   // ==========================================================
   // write protect
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         host_wp <= 1'b1;
      end else begin
         host_wp <= drive_wp || !media_present; // R10
      end
   end
   // ==========================================================
   // checks
   sequence s_fdc_res_read;
      reg_rd && reg_addr == OFF_FDC_RES;
   endsequence
   sequence s_hdc_res_read;
      reg_rd && reg_addr == OFF_HDC_RES;
   endsequence
   AST_FDC_LEGACY: assert property ( // R1
      @(posedge core_clk) disable iff (!rst_sync_n)
      io_strobe && fdc_en && fdc_io == 4'h0 && io_addr == 16'h03f5
      |=> fdc_cs && io_ofs == 3'h5)
      else $error("floppy missed legacy data port");
   AST_FDC_NO_SHARED: assert property ( // R2
      @(posedge core_clk) disable iff (!rst_sync_n)
      s_fdc_res_read |=> reg_rdata[7] == 1'b0 && reg_rdata[2] == 1'b1)
      else $error("floppy claims the shared port");
   AST_FDC_SECONDARY: assert property ( // R7
      @(posedge core_clk) disable iff (!rst_sync_n)
      io_strobe && fdc_en && fdc_io == 4'h1 && io_addr == 16'h0372
      |=> fdc_cs && io_ofs == FDC_OFS_A)
      else $error("floppy missed secondary set");
   AST_FDC_IRQ6: assert property ( // R3
      @(posedge core_clk) disable iff (!rst_sync_n)
      fdc_en && fdc_irq_sel == 3'h0 && fdc_irq_req |=> irq_line[6])
      else $error("floppy interrupt not on line 6");
   AST_FDC_DMA2: assert property ( // R4
      @(posedge core_clk) disable iff (!rst_sync_n)
      fdc_en && fdc_dma_sel == 2'h0 && fdc_drq_req && dack_line[2]
      |=> drq_line[2] && fdc_dack)
      else $error("floppy dma not on channel 2");
   AST_OFF_QUIET: assert property ( // R18
      @(posedge core_clk) disable iff (!rst_sync_n)
      !fdc_en && !hdc_en [*2] |-> irq_line == '0 && drq_line == '0 &&
      !fdc_cs && !hdc_cmd_cs && !hdc_ctl_cs)
      else $error("disabled controllers still active");
   AST_INDEPENDENT: assert property ( // R6
      @(posedge core_clk) disable iff (!rst_sync_n)
      !fdc_en && hdc_en && hdc_io == 3'h0 && io_strobe &&
      io_addr == 16'h01f7 |=> hdc_cmd_cs && !fdc_cs)
      else $error("hard disk lost decode with floppy off");
   AST_HDC_CTL: assert property ( // R12
      @(posedge core_clk) disable iff (!rst_sync_n)
      hdc_ctl_cs |-> io_ofs == HDC_CTL_OFS && $past(io_strobe))
      else $error("hard disk control select on wrong offset");
   AST_HDC_IRQ14: assert property ( // R13
      @(posedge core_clk) disable iff (!rst_sync_n)
      hdc_en && hdc_irq_sel == 3'h0 && hdc_irq_req |=> irq_line[14])
      else $error("hard disk interrupt not on line 14");
   AST_HDC_NO_SHARED: assert property ( // R15
      @(posedge core_clk) disable iff (!rst_sync_n)
      s_hdc_res_read |=> reg_rdata[7:0] == HDC_CTL_CLAIM_MASK)
      else $error("hard disk claims the shared port");
   AST_WP_NO_MEDIA: assert property ( // R10
      @(posedge core_clk) disable iff (!rst_sync_n)
      !media_present [*2] |-> host_wp)
      else $error("write protect low with no medium");
   AST_FDC_IO_OFF: assert property ( // R9
      @(posedge core_clk) disable iff (!rst_sync_n)
      fdc_io == FDC_IO_OFF [*2] |-> !fdc_cs && !fdc_shared_cs)
      else $error("floppy decodes with decode off");
endmodule
`default_nettype wire

/* hw/disk_ctrl_pkg.sv */
// constants shared by the disk controller resource decoder
package disk_ctrl_pkg;
   // ==========================================================
   // register port
   localparam int REG_AW = 8;
   localparam int REG_DW = 16;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_FDC_IO = 8'h04;
   localparam logic [7:0] OFF_FDC_IRQ = 8'h08;
   localparam logic [7:0] OFF_FDC_DMA = 8'h0c;
   localparam logic [7:0] OFF_HDC_IO = 8'h10;
   localparam logic [7:0] OFF_HDC_IRQ = 8'h14;
   localparam logic [7:0] OFF_HDC_DMA = 8'h18;
   localparam logic [7:0] OFF_FDC_RES = 8'h1c;
   localparam logic [7:0] OFF_HDC_RES = 8'h20;
   localparam logic [7:0] OFF_INT_STATUS = 8'h24;
   localparam logic [7:0] OFF_INT_MASK = 8'h28;
   localparam logic [7:0] OFF_STATUS = 8'h2c;
   // ==========================================================
   // control fields and reset values
   localparam int CTRL_FDC_EN = 0;
   localparam int CTRL_HDC_EN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int INT_FDC = 0;
   localparam int INT_HDC = 1;
   localparam int INT_MEDIA = 2;
   localparam int INT_W = 3;
   localparam int STAT_MEDIA = 0;
   localparam int STAT_WP = 1;
   // ==========================================================
   // i/o address sets
   localparam int IO_AW = 16;
   localparam logic [3:0] FDC_IO_OFF = 4'h8;
   localparam logic [3:0] FDC_IO_RESET = 4'h0;
   localparam logic [IO_AW-1:0] FDC_BASE [0:7] = '{16'h03f0, 16'h0370,
      16'h03e0, 16'h0360, 16'h02f0, 16'h0270, 16'h02e0, 16'h0260};
   localparam logic [2:0] FDC_OFS_A = 3'h2;
   localparam logic [2:0] FDC_OFS_B = 3'h4;
   localparam logic [2:0] FDC_OFS_C = 3'h5;
   localparam logic [2:0] SHARED_OFS = 3'h7;
   localparam logic [2:0] HDC_IO_OFF = 3'h7;
   localparam logic [2:0] HDC_IO_RESET = 3'h0;
   localparam logic [IO_AW-1:0] HDC_CMD_BASE [0:6] = '{16'h01f0,
      16'h0170, 16'h01e8, 16'h0168, 16'h01e0, 16'h0160, 16'h01d8};
   localparam logic [IO_AW-1:0] HDC_CTL_BASE [0:6] = '{16'h03f0,
      16'h0370, 16'h03e0, 16'h0360, 16'h03e8, 16'h0368, 16'h03d8};
   localparam logic [2:0] HDC_CTL_OFS = 3'h6;
   // claimed-offset maps reported to software; shared offset bit clear
   localparam logic [7:0] FDC_CLAIM_MASK = 8'h34;
   localparam logic [7:0] HDC_CTL_CLAIM_MASK = 8'h40;
   // ==========================================================
   // interrupt and dma routing tables, last code disconnects
   localparam logic [2:0] IRQ_NONE = 3'h7;
   localparam logic [1:0] DMA_NONE = 2'h3;
   localparam int FDC_IRQ_MAP [0:7] = '{6, 3, 4, 5, 7, 10, 11, 0};
   localparam int HDC_IRQ_MAP [0:7] = '{14, 15, 10, 11, 12, 9, 5, 0};
   localparam int FDC_DMA_MAP [0:7] = '{2, 1, 3, 0, 0, 0, 0, 0};
   localparam int HDC_DMA_MAP [0:7] = '{3, 5, 6, 0, 0, 0, 0, 0};
   localparam int IRQ_LINES_MIN = 16;
   localparam int DMA_CHANS_MIN = 8;
endpackage

/* hw/request_router.sv */
// steers one request onto a selected host line and picks its acknowledge
`timescale 1ns/1ps
`default_nettype none
module request_router #(
   parameter int LINES = 16,
   parameter int SELW = 3,
   parameter int unsigned NONE_CODE = 7,
   parameter int MAP [0:7] = '{0, 0, 0, 0, 0, 0, 0, 0}
) (
   input wire logic enable,
   input wire logic [SELW-1:0] sel,
   input wire logic req,
   input wire logic [LINES-1:0] ack_in,
   output logic [LINES-1:0] line_out,
   output logic ack_out
);
   logic valid;

   // the routing table holds eight codes, so a wider select cannot be served
   if (SELW < 1 || SELW > 3) begin : g_chk_sel
      $error("SELW does not fit the routing table");
   end

   // disabled or disconnected: nothing reaches the host lines
   assign valid = enable && (32'(sel) != NONE_CODE);

   always_comb begin
      line_out = '0;
      ack_out = 1'b0;
      for (int i = 0; i < LINES; i++) begin
         if (valid && (MAP[sel] == i)) begin
            line_out[i] = req;
            ack_out = ack_in[i];
         end
      end
   end
endmodule
`default_nettype wire

/* bench/host_dma_model.sv */
// host side dma acknowledge model facing the decoder's request lines
`timescale 1ns/1ps
`default_nettype none
module host_dma_model #(
   parameter int CHANS = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic [CHANS-1:0] drq_line,
   output logic [CHANS-1:0] dack_line
);
   logic [2:0] wait_cnt;
   // one grant at a time, lowest channel wins, dropped with the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt <= 3'h0;
         dack_line <= '0;
      end else if (drq_line == '0) begin
         wait_cnt <= 3'h0;
         dack_line <= '0;
      end else if (wait_cnt < (slow ? 3'h4 : 3'h1)) begin
         wait_cnt <= wait_cnt + 3'h1;
      end else begin
         dack_line <= drq_line & ~(drq_line - 1'b1);
      end
   end
endmodule
`default_nettype wire

/* bench/disk_ctrl_resource_decoder_tb_top.sv */
// self-checking bench for the disk controller resource decoder
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end
module disk_ctrl_resource_decoder_tb_top;
   import disk_ctrl_pkg::*;
   logic core_clk, rst_n, reg_wr, reg_rd, io_strobe, slow, dev_int;
   logic [7:0] reg_addr, drq_line, dack_line, e8;
   logic [15:0] reg_wdata, reg_rdata, io_addr, irq_line, e16;
   logic fdc_irq_req, hdc_irq_req, fdc_drq_req, hdc_drq_req;
   logic media_present, drive_wp, host_wp, fdc_dack, hdc_dack;
   logic fdc_cs, fdc_shared_cs, hdc_cmd_cs, hdc_ctl_cs;
   logic [2:0] io_ofs;
   int failures, samples_checked, cycles;

   disk_ctrl_resource_decoder dut_u (
      .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .dev_int, .io_addr, .io_strobe, .fdc_cs,
      .fdc_shared_cs, .hdc_cmd_cs, .hdc_ctl_cs, .io_ofs, .fdc_irq_req,
      .hdc_irq_req, .fdc_drq_req, .hdc_drq_req, .fdc_dack, .hdc_dack,
      .irq_line, .drq_line, .dack_line, .media_present, .drive_wp,
      .host_wp
   );
   host_dma_model host_u (
      .clk(core_clk), .rst_n, .slow, .drq_line, .dack_line
   );

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // ====
   // bus tasks
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         test_done();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      `CHECK(reg_rdata, e)
   endtask
   task automatic io(input logic [15:0] a, input logic [3:0] e);
      @(posedge core_clk);
      io_strobe <= 1'b1;
      io_addr <= a;
      @(posedge core_clk);
      io_strobe <= 1'b0;
      @(negedge core_clk);
      `CHECK({fdc_cs, fdc_shared_cs, hdc_cmd_cs, hdc_ctl_cs}, e)
      `CHECK(io_ofs, a[2:0])
   endtask
   task automatic chk_irq(input logic hd, input logic [2:0] c,
         input logic [15:0] e);
      wr(hd ? OFF_HDC_IRQ : OFF_FDC_IRQ, {13'h0, c});
      fdc_irq_req <= !hd;
      hdc_irq_req <= hd;
      cyc(3);
      @(negedge core_clk);
      `CHECK(irq_line, e)
      cyc(1);
      fdc_irq_req <= 1'b0;
      hdc_irq_req <= 1'b0;
      cyc(3);
   endtask
   task automatic chk_dma(input logic hd, input logic [1:0] c,
         input logic [7:0] e);
      wr(hd ? OFF_HDC_DMA : OFF_FDC_DMA, {14'h0, c});
      fdc_drq_req <= !hd;
      hdc_drq_req <= hd;
      cyc(10);
      @(negedge core_clk);
      `CHECK(drq_line, e)
      `CHECK(hd ? hdc_dack : fdc_dack, e != 8'h0)
      cyc(1);
      fdc_drq_req <= 1'b0;
      hdc_drq_req <= 1'b0;
      cyc(10);
      @(negedge core_clk);
      `CHECK({fdc_dack, hdc_dack, drq_line}, 10'h0)
   endtask
   // ====
   // tests
   initial begin
      rst_n = 1'b0;
      {reg_wr, reg_rd, io_strobe, slow, fdc_irq_req, hdc_irq_req,
         fdc_drq_req, hdc_drq_req, drive_wp} = '0;
      {reg_addr, reg_wdata, io_addr} = '0;
      media_present = 1'b1;
      cyc(16);
      rst_n <= 1'b1;
      cyc(4);
      rdc(OFF_CTRL, 16'h0003);
      rdc(OFF_INT_STATUS, 16'h0000);
      wr(OFF_FDC_RES, 16'h00ff);
      rdc(OFF_FDC_RES, 16'h0034);
      rdc(OFF_HDC_RES, 16'h0040);
      rdc(8'h3c, 16'h0000);
      $display("test reset done");
      io(16'h03f2, 4'h8);
      io(16'h03f4, 4'h8);
      io(16'h03f5, 4'h8);
      io(16'h03f7, 4'h4);
      io(16'h03f6, 4'h1);
      for (int i = 0; i < 8; i++) io(16'(16'h01f0 + i), 4'h2);
      wr(OFF_FDC_IO, 16'h0001);
      io(16'h0372, 4'h8);
      io(16'h0374, 4'h8);
      io(16'h0375, 4'h8);
      io(16'h0377, 4'h4);
      io(16'h03f2, 4'h0);
      for (int i = 0; i < 8; i++) begin
         wr(OFF_FDC_IO, 16'(i));
         io(FDC_BASE[i] + 16'h0005, 4'h8);
      end
      wr(OFF_FDC_IO, 16'h000f);
      rdc(OFF_FDC_IO, 16'h0008);
      io(16'h03f5, 4'h0);
      wr(OFF_FDC_IO, 16'h0000);
      for (int i = 1; i < 8; i++) begin
         wr(OFF_HDC_IO, 16'(i));
         if (i < 7) begin
            io(HDC_CMD_BASE[i] + 16'h0003, 4'h2);
            io(HDC_CTL_BASE[i] + 16'h0006, 4'h1);
         end else begin
            io(16'h01f3, 4'h0);
            io(16'h03f6, 4'h0);
         end
      end
      rdc(OFF_HDC_IO, 16'h0007);
      wr(OFF_HDC_IO, 16'h0000);
      $display("test decode done");
      chk_irq(1'b0, 3'h0, 16'h0040);
      chk_irq(1'b1, 3'h0, 16'h4000);
      for (int i = 1; i < 8; i++) begin
         e16 = (i == 7) ? 16'h0 : 16'h1 << FDC_IRQ_MAP[i];
         chk_irq(1'b0, 3'(i), e16);
         e16 = (i == 7) ? 16'h0 : 16'h1 << HDC_IRQ_MAP[i];
         chk_irq(1'b1, 3'(i), e16);
      end
      chk_dma(1'b0, 2'h0, 8'h04);
      for (int i = 0; i < 4; i++) begin
         slow <= i[0];
         e8 = (i == 3) ? 8'h0 : 8'h1 << FDC_DMA_MAP[i];
         chk_dma(1'b0, 2'(i), e8);
         e8 = (i == 3) ? 8'h0 : 8'h1 << HDC_DMA_MAP[i];
         chk_dma(1'b1, 2'(i), e8);
      end
      wr(OFF_FDC_DMA, 16'h0000);
      wr(OFF_HDC_DMA, 16'h0000);
      wr(OFF_FDC_IRQ, 16'h0000);
      wr(OFF_HDC_IRQ, 16'h0000);
      $display("test routing done");
      wr(OFF_CTRL, 16'h0002);
      io(16'h03f2, 4'h0);
      io(16'h01f7, 4'h2);
      cyc(1);
      {fdc_irq_req, hdc_irq_req, fdc_drq_req, hdc_drq_req} <= 4'hf;
      cyc(10);
      @(negedge core_clk);
      `CHECK(irq_line, 16'h4000)
      `CHECK(drq_line, 8'h08)
      wr(OFF_CTRL, 16'h0001);
      cyc(4);
      @(negedge core_clk);
      `CHECK(irq_line, 16'h0040)
      `CHECK(drq_line, 8'h04)
      io(16'h01f0, 4'h0);
      io(16'h03f6, 4'h0);
      io(16'h03f5, 4'h8);
      wr(OFF_CTRL, 16'h0000);
      cyc(3);
      @(negedge core_clk);
      `CHECK({irq_line, fdc_dack, hdc_dack, drq_line}, 26'h0)
      io(16'h01f0, 4'h0);
      io(16'h03f5, 4'h0);
      cyc(1);
      {fdc_irq_req, hdc_irq_req, fdc_drq_req, hdc_drq_req} <= 4'h0;
      wr(OFF_CTRL, 16'h0003);
      $display("test disable done");
      wr(OFF_INT_STATUS, 16'h0007);
      wr(OFF_INT_MASK, 16'h0004);
      rdc(OFF_INT_MASK, 16'h0004);
      cyc(1);
      media_present <= 1'b0;
      cyc(4);
      @(negedge core_clk);
      `CHECK(host_wp, 1'b1)
      `CHECK(dev_int, 1'b1)
      rdc(OFF_STATUS, 16'h0002);
      rdc(OFF_INT_STATUS, 16'h0004);
      wr(OFF_INT_MASK, 16'h0000);
      cyc(3);
      @(negedge core_clk);
      `CHECK(dev_int, 1'b0)
      wr(OFF_INT_STATUS, 16'h0004);
      rdc(OFF_INT_STATUS, 16'h0000);
      cyc(1);
      media_present <= 1'b1;
      cyc(4);
      @(negedge core_clk);
      `CHECK({host_wp, dev_int}, 2'h0)
      cyc(1);
      drive_wp <= 1'b1;
      rdc(OFF_INT_STATUS, 16'h0004);
      rdc(OFF_STATUS, 16'h0003);
      $display("test status done");
      test_done();
   end
endmodule
`default_nettype wire
